// >>> rtl/srs_status_sets.sv
// Eleven status register sets: condition, event latch, enable and two edge filters each.
// Assumes commands arrive synchronous to i_sys_clk, one per cycle at most, already as integers.
`default_nettype none

// What this block does
// RL1 - Power-on presets filters, enables; clears events, queue.
// RL2 - Clear-status clears events, queue, status byte only.
// RL3 - Status preset loads filters and enables only.
// RL4 - Condition read returns value, leaves it unchanged.
// RL5 - Event read returns value, then clears it.
// RL6 - Enable write stores low 15 bits.
// RL7 - Enable read returns stored 15 bits.
// RL8 - Falling filter write stores 15 bits, reads back.
// RL9 - Rising filter write stores 15 bits, reads back.
// RL10 - Device bits 1,2 show sensor attached.
// RL11 - Falling filter latches sensor removal event.
// RL12 - Rising filter latches sensor attachment event.
// RL13 - Bits 3,4 flag memory fault or double attachment.
// RL14 - Bits 5,6 show rear connector attachment.
// RL15 - Key press latches event bit 14 unfiltered.
// RL16 - Key press condition bit reads zero.
// RL17 - Preset values differ for operation, questionable sets.
// RL18 - Summary ORs enabled events into parent condition.
// RL19 - Events latch only on filter-permitted edges, except key press bit 14.
module srs_status_sets
    import srs_pkg::*;
(
    input wire logic i_sys_clk,
    input wire logic i_reset,
    input wire logic i_cmd_valid,
    input wire srs_cmd_t i_cmd,
    input wire logic i_clear_status,
    input wire logic i_status_preset,
    input wire srs_sensor_t i_sensor,
    input wire logic i_key_press,
    input wire logic [SRS_NUM_SETS-1:1][15:0] i_raw_cond,
    output logic o_rsp_valid,
    output logic [15:0] o_rsp_data,
    output logic [SRS_NUM_SETS-1:0] o_set_summary,
    output srs_ext_t o_ext
);

    logic [15:0] enable_reg [SRS_NUM_SETS];
    logic [15:0] rise_filter [SRS_NUM_SETS];
    logic [15:0] fall_filter [SRS_NUM_SETS];
    logic [15:0] event_latch [SRS_NUM_SETS];
    logic [15:0] prev_cond [SRS_NUM_SETS];
    logic [15:0] cond [SRS_NUM_SETS];
    logic [15:0] new_event [SRS_NUM_SETS];
    logic [15:0] device_cond;
    logic [SRS_NUM_SETS-1:0] summary;
    logic [15:0] next_rsp_data;
    logic set_valid;

    // Operation and questionable sets preset to a quiet enable and a silent falling filter.
    function automatic logic [15:0] preset_enable(input int idx);
        preset_enable = (idx == int'(SRS_SET_OPER) || idx == int'(SRS_SET_QUES)) ? SRS_ALL_ZERO : SRS_STORE_MASK;
    endfunction

    function automatic logic hit(input logic valid, input srs_cmd_t cmd, input int idx, input srs_reg_sel_t sel,
                                 input logic wr);
        hit = valid && cmd.set == 4'(idx) && cmd.sel == sel && cmd.write == wr;
    endfunction

    assign set_valid = i_cmd.set < 4'(SRS_NUM_SETS);

    // Device condition bits come straight from the sensor pins.
    always_comb begin
        device_cond = SRS_ALL_ZERO;
        for (int ch = 0; ch < SRS_CHANNELS; ch++) begin
            device_cond[SRS_DEV_ATTACHED_LSB + ch] = i_sensor.front_present[ch] | i_sensor.rear_present[ch]; // RL10
            device_cond[SRS_DEV_ERROR_LSB + ch] = i_sensor.memory_failed[ch] |
                                                  (i_sensor.front_present[ch] & i_sensor.rear_present[ch]); // RL13
            device_cond[SRS_DEV_REAR_LSB + ch] = i_sensor.rear_present[ch]; // RL14
        end
        device_cond[SRS_DEV_KEY_BIT] = 1'b0; // RL16
    end

    // Summaries are taken from registered events and enables, so there is no combinational loop.
    always_comb begin
        for (int i = 0; i < SRS_NUM_SETS; i++) begin
            summary[i] = |(event_latch[i] & enable_reg[i]); // RL18
        end
    end

    assign o_set_summary = summary;

    always_comb begin
        cond[0] = device_cond;
        for (int i = 1; i < SRS_NUM_SETS; i++) begin
            cond[i] = i_raw_cond[i] & SRS_STORE_MASK;
        end
        for (int i = 0; i < SRS_NUM_SETS; i++) begin
            if (SRS_HAS_PARENT[i]) begin
                cond[SRS_PARENT[i]][SRS_PARENT_BIT[i]] = cond[SRS_PARENT[i]][SRS_PARENT_BIT[i]] | summary[i]; // RL18
            end
        end
    end

    always_comb begin
        for (int i = 0; i < SRS_NUM_SETS; i++) begin
            new_event[i] = ((cond[i] & ~prev_cond[i] & rise_filter[i]) | // RL12 RL19
                            (~cond[i] & prev_cond[i] & fall_filter[i])) & SRS_STORE_MASK; // RL11 RL19
        end
        new_event[0][SRS_DEV_KEY_BIT] = i_key_press; // RL15
    end

    always_ff @(posedge i_sys_clk) begin
        for (int i = 0; i < SRS_NUM_SETS; i++) begin
            if (i_reset) begin
                prev_cond[i] <= SRS_ALL_ZERO;
            end else begin
                prev_cond[i] <= cond[i];
            end
        end
    end

    // Preset beats a write in the same cycle; clear-status has no path into these registers.
    always_ff @(posedge i_sys_clk) begin
        for (int i = 0; i < SRS_NUM_SETS; i++) begin
            if (i_reset || i_status_preset) begin
                enable_reg[i] <= preset_enable(i); // RL1 RL3 RL17
            end else if (hit(i_cmd_valid, i_cmd, i, SRS_REG_ENABLE, 1'b1)) begin
                enable_reg[i] <= i_cmd.data & SRS_STORE_MASK; // RL6
            end
        end
    end

    always_ff @(posedge i_sys_clk) begin
        for (int i = 0; i < SRS_NUM_SETS; i++) begin
            if (i_reset || i_status_preset) begin
                rise_filter[i] <= SRS_STORE_MASK; // RL1 RL3 RL17
            end else if (hit(i_cmd_valid, i_cmd, i, SRS_REG_RISE, 1'b1)) begin
                rise_filter[i] <= i_cmd.data & SRS_STORE_MASK; // RL9
            end
        end
    end

    always_ff @(posedge i_sys_clk) begin
        for (int i = 0; i < SRS_NUM_SETS; i++) begin
            if (i_reset || i_status_preset) begin
                fall_filter[i] <= SRS_ALL_ZERO; // RL1 RL3 RL17
            end else if (hit(i_cmd_valid, i_cmd, i, SRS_REG_FALL, 1'b1)) begin
                fall_filter[i] <= i_cmd.data & SRS_STORE_MASK; // RL8
            end
        end
    end

    // An edge arriving in the cycle of a read or clear survives it.
    always_ff @(posedge i_sys_clk) begin
        for (int i = 0; i < SRS_NUM_SETS; i++) begin
            if (i_reset) begin
                event_latch[i] <= SRS_ALL_ZERO; // RL1
            end else if (i_clear_status || hit(i_cmd_valid, i_cmd, i, SRS_REG_EVENT, 1'b0)) begin
                event_latch[i] <= new_event[i]; // RL2 RL5
            end else begin
                event_latch[i] <= event_latch[i] | new_event[i];
            end
        end
    end

    always_comb begin
        next_rsp_data = SRS_ALL_ZERO;
        if (set_valid) begin
            unique case (i_cmd.sel)
                SRS_REG_CONDITION: next_rsp_data = cond[i_cmd.set]; // RL4
                SRS_REG_EVENT: next_rsp_data = event_latch[i_cmd.set]; // RL5
                SRS_REG_ENABLE: next_rsp_data = enable_reg[i_cmd.set]; // RL7
                SRS_REG_RISE: next_rsp_data = rise_filter[i_cmd.set]; // RL9
                SRS_REG_FALL: next_rsp_data = fall_filter[i_cmd.set]; // RL8
                default: next_rsp_data = SRS_ALL_ZERO;
            endcase
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_reset) begin
            o_rsp_valid <= 1'b0;
            o_rsp_data <= SRS_ALL_ZERO;
        end else begin
            o_rsp_valid <= i_cmd_valid && !i_cmd.write;
            if (i_cmd_valid && !i_cmd.write) begin
                o_rsp_data <= next_rsp_data & SRS_STORE_MASK;
            end
        end
    end

    // The queue and standard registers live outside; through power-on they are held clear and the queue enable is held preset.
    always_ff @(posedge i_sys_clk) begin
        if (i_reset) begin
            o_ext <= '{queue_clear: 1'b1, queue_enable_preset: 1'b1, std_status_clear: 1'b1,
                       std_enable_clear: 1'b1}; // RL1
        end else begin
            o_ext.queue_clear <= i_clear_status; // RL2
            o_ext.std_status_clear <= i_clear_status; // RL2
            o_ext.queue_enable_preset <= i_status_preset; // RL3
            o_ext.std_enable_clear <= 1'b0;
        end
    end

    // Checks.

    sequence s_write_dev(srs_reg_sel_t sel);
        i_cmd_valid && i_cmd.write && i_cmd.set == SRS_SET_DEVICE && i_cmd.sel == sel && !i_status_preset;
    endsequence

    sequence s_read_dev(srs_reg_sel_t sel);
        i_cmd_valid && !i_cmd.write && i_cmd.set == SRS_SET_DEVICE && i_cmd.sel == sel;
    endsequence

    property p_power_on;
        @(posedge i_sys_clk) disable iff (i_reset)
        $fell(i_reset) |-> event_latch[0] == SRS_ALL_ZERO && enable_reg[1] == SRS_ALL_ZERO &&
                           rise_filter[1] == SRS_STORE_MASK && o_ext.queue_clear;
    endproperty
    a_power_on: assert property (p_power_on) else $error("power-on state wrong"); // RL1

    property p_clear_status;
        @(posedge i_sys_clk) disable iff (i_reset)
        i_clear_status && new_event[1] == SRS_ALL_ZERO && !i_status_preset && !i_cmd_valid
        |=> event_latch[1] == SRS_ALL_ZERO && $stable(enable_reg[1]) && $stable(fall_filter[1]) && o_ext.queue_clear;
    endproperty
    a_clear_status: assert property (p_clear_status) else $error("clear-status effect wrong"); // RL2

    property p_preset;
        @(posedge i_sys_clk) disable iff (i_reset)
        i_status_preset |=> enable_reg[2] == SRS_ALL_ZERO && enable_reg[0] == SRS_STORE_MASK &&
                            fall_filter[0] == SRS_ALL_ZERO && rise_filter[2] == SRS_STORE_MASK;
    endproperty
    a_preset: assert property (p_preset) else $error("preset values wrong"); // RL3

    property p_cond_read;
        @(posedge i_sys_clk) disable iff (i_reset)
        s_read_dev(SRS_REG_CONDITION) |=> o_rsp_valid && o_rsp_data == $past(device_cond) && !o_rsp_data[15];
    endproperty
    a_cond_read: assert property (p_cond_read) else $error("condition read wrong"); // RL4

    property p_event_read;
        @(posedge i_sys_clk) disable iff (i_reset)
        s_read_dev(SRS_REG_EVENT) ##0 (new_event[0] == SRS_ALL_ZERO)
        |=> o_rsp_valid && o_rsp_data == $past(event_latch[0]) && event_latch[0] == SRS_ALL_ZERO;
    endproperty
    a_event_read: assert property (p_event_read) else $error("event read did not clear"); // RL5

    property p_enable_roundtrip;
        @(posedge i_sys_clk) disable iff (i_reset)
        s_write_dev(SRS_REG_ENABLE) ##1 (!i_cmd_valid && !i_status_preset)
        ##1 (s_read_dev(SRS_REG_ENABLE) and !i_status_preset)
        |=> o_rsp_data == ($past(i_cmd.data, 3) & SRS_STORE_MASK);
    endproperty
    a_enable_roundtrip: assert property (p_enable_roundtrip) else $error("enable readback wrong"); // RL6

    property p_fall_write;
        @(posedge i_sys_clk) disable iff (i_reset)
        s_write_dev(SRS_REG_FALL) |=> fall_filter[0] == ($past(i_cmd.data) & SRS_STORE_MASK) && !fall_filter[0][15];
    endproperty
    a_fall_write: assert property (p_fall_write) else $error("falling filter write wrong"); // RL8

    property p_rise_write;
        @(posedge i_sys_clk) disable iff (i_reset)
        s_write_dev(SRS_REG_RISE) |=> rise_filter[0] == ($past(i_cmd.data) & SRS_STORE_MASK);
    endproperty
    a_rise_write: assert property (p_rise_write) else $error("rising filter write wrong"); // RL9

    property p_attached;
        @(posedge i_sys_clk) disable iff (i_reset)
        (i_sensor.front_present[0] || i_sensor.rear_present[0]) |-> cond[0][SRS_DEV_ATTACHED_LSB];
    endproperty
    a_attached: assert property (p_attached) else $error("attached bit not shown"); // RL10

    property p_removal;
        @(posedge i_sys_clk) disable iff (i_reset)
        $fell(device_cond[SRS_DEV_ATTACHED_LSB]) && fall_filter[0][SRS_DEV_ATTACHED_LSB]
        |=> event_latch[0][SRS_DEV_ATTACHED_LSB];
    endproperty
    a_removal: assert property (p_removal) else $error("removal not latched"); // RL11

    property p_attach;
        @(posedge i_sys_clk) disable iff (i_reset)
        $rose(device_cond[SRS_DEV_ATTACHED_LSB]) && rise_filter[0][SRS_DEV_ATTACHED_LSB]
        |=> event_latch[0][SRS_DEV_ATTACHED_LSB];
    endproperty
    a_attach: assert property (p_attach) else $error("attachment not latched"); // RL12

    property p_no_filtered_edge;
        @(posedge i_sys_clk) disable iff (i_reset)
        $stable(device_cond) && !$past(i_reset) && !i_key_press &&
        (i_clear_status || (i_cmd_valid && !i_cmd.write && i_cmd.set == SRS_SET_DEVICE && i_cmd.sel == SRS_REG_EVENT))
        |=> event_latch[0] == SRS_ALL_ZERO;
    endproperty
    a_no_filtered_edge: assert property (p_no_filtered_edge) else $error("event without edge"); // RL19

    property p_key_press;
        @(posedge i_sys_clk) disable iff (i_reset)
        i_key_press |=> event_latch[0][SRS_DEV_KEY_BIT] && !device_cond[SRS_DEV_KEY_BIT];
    endproperty
    a_key_press: assert property (p_key_press) else $error("key press not latched"); // RL15

    property p_summary;
        @(posedge i_sys_clk) disable iff (i_reset)
        event_latch[3][1] && enable_reg[3][1] |-> o_set_summary[3] && cond[SRS_SET_OPER][0];
    endproperty
    a_summary: assert property (p_summary) else $error("summary not forwarded"); // RL18

    property p_rsp_clean;
        @(posedge i_sys_clk) disable iff (i_reset)
        o_rsp_valid |-> !o_rsp_data[15];
    endproperty
    a_rsp_clean: assert property (p_rsp_clean) else $error("answer bit 15 set"); // RL4

    property p_write_silent;
        @(posedge i_sys_clk) disable iff (i_reset)
        i_cmd_valid && i_cmd.write |=> !o_rsp_valid;
    endproperty
    a_write_silent: assert property (p_write_silent) else $error("write produced an answer"); // RL6

    property p_preset_keeps_events;
        @(posedge i_sys_clk) disable iff (i_reset)
        i_status_preset && !i_clear_status && !i_cmd_valid |=> event_latch[0] == ($past(event_latch[0]) | $past(new_event[0]));
    endproperty
    a_preset_keeps_events: assert property (p_preset_keeps_events) else $error("preset touched events"); // RL3

    property p_clear_pulses;
        @(posedge i_sys_clk) disable iff (i_reset)
        i_clear_status |=> o_ext.queue_clear && o_ext.std_status_clear && !o_ext.std_enable_clear;
    endproperty
    a_clear_pulses: assert property (p_clear_pulses) else $error("clear-status pulses wrong"); // RL2

    property p_invalid_read;
        @(posedge i_sys_clk) disable iff (i_reset)
        i_cmd_valid && !i_cmd.write && !set_valid |=> o_rsp_valid && o_rsp_data == SRS_ALL_ZERO;
    endproperty
    a_invalid_read: assert property (p_invalid_read) else $error("unknown set read not zero"); // RL7

    property p_rear_shown;
        @(posedge i_sys_clk) disable iff (i_reset)
        i_sensor.rear_present[1] |-> cond[0][SRS_DEV_REAR_LSB + 1] && cond[0][SRS_DEV_ATTACHED_LSB + 1];
    endproperty
    a_rear_shown: assert property (p_rear_shown) else $error("rear attachment not shown"); // RL14

    property p_double_error;
        @(posedge i_sys_clk) disable iff (i_reset)
        i_sensor.front_present[0] && i_sensor.rear_present[0] |-> cond[0][SRS_DEV_ERROR_LSB];
    endproperty
    a_double_error: assert property (p_double_error) else $error("double attachment not flagged"); // RL13

endmodule // srs_status_sets

`default_nettype wire

// >>> rtl/srs_pkg.sv
// Constants, command and pin carriers for the status register sets.
// Assumes a host-side parser that hands over integer register values.
`default_nettype none

package srs_pkg;

    localparam int SRS_NUM_SETS = 11;
    localparam int SRS_WIDTH = 16;

    // Set indices as used in the command set field.
    localparam logic [3:0] SRS_SET_DEVICE = 4'h0;
    localparam logic [3:0] SRS_SET_OPER = 4'h1;
    localparam logic [3:0] SRS_SET_QUES = 4'h2;

    // Parent linkage of sets 3 to 10: parent index and the condition bit each drives there; sets 0 to 2 have none.
    localparam logic [SRS_NUM_SETS-1:0] SRS_HAS_PARENT = 11'h7F8;
    localparam logic [3:0] SRS_PARENT [SRS_NUM_SETS] = '{4'h0, 4'h0, 4'h0, 4'h1, 4'h1, 4'h1,
                                                          4'h1, 4'h1, 4'h1, 4'h2, 4'h2};
    localparam logic [3:0] SRS_PARENT_BIT [SRS_NUM_SETS] = '{4'h0, 4'h0, 4'h0, 4'h0, 4'hB, 4'h4,
                                                              4'hA, 4'h5, 4'hC, 4'h8, 4'h3};

    // Stored values keep bits 14..0; bit 15 is always zero.
    localparam logic [15:0] SRS_STORE_MASK = 16'h7FFF;
    localparam logic [15:0] SRS_ALL_ZERO = 16'h0000;

    // Device set field positions.
    localparam int SRS_DEV_ATTACHED_LSB = 1;
    localparam int SRS_DEV_ERROR_LSB = 3;
    localparam int SRS_DEV_REAR_LSB = 5;
    localparam int SRS_DEV_KEY_BIT = 14;
    localparam int SRS_CHANNELS = 2;

    typedef enum logic [2:0] {
        SRS_REG_CONDITION,
        SRS_REG_EVENT,
        SRS_REG_ENABLE,
        SRS_REG_RISE,
        SRS_REG_FALL
    } srs_reg_sel_t;

    typedef struct packed {
        logic [3:0] set;
        srs_reg_sel_t sel;
        logic write;
        logic [15:0] data;
    } srs_cmd_t;

    typedef struct packed {
        logic [1:0] front_present;
        logic [1:0] rear_present;
        logic [1:0] memory_failed;
    } srs_sensor_t;

    typedef struct packed {
        logic queue_clear;
        logic queue_enable_preset;
        logic std_status_clear;
        logic std_enable_clear;
    } srs_ext_t;

endpackage : srs_pkg

`default_nettype wire

// >>> sim/srs_host_model.sv
// Remote host model: issues one status register command per call and collects the read answer.
// Assumes the block answers a read at the edge that takes the command, readable at the next falling edge.
`default_nettype none

module srs_host_model
    import srs_pkg::*;
(
    input wire logic i_sys_clk,
    input wire logic i_rsp_valid,
    input wire logic [15:0] i_rsp_data,
    output logic o_cmd_valid,
    output var srs_cmd_t o_cmd
);
    timeunit 1ns;
    timeprecision 1ns;

    initial begin
        o_cmd_valid = 1'b0;
        o_cmd = '0;
    end

    // The strobe drops at the taking edge, so two calls in a row never merge into one command.
    task automatic issue(input logic [3:0] set, input srs_reg_sel_t sel, input logic wr,
                         input logic [15:0] data, output logic got, output logic [15:0] rdata);
        @(posedge i_sys_clk);
        o_cmd <= '{set: set, sel: sel, write: wr, data: data};
        o_cmd_valid <= 1'b1;
        @(posedge i_sys_clk);
        o_cmd_valid <= 1'b0;
        // Scramble the data once it no longer qualifies a command.
        o_cmd.data <= ~data;
        @(negedge i_sys_clk);
        got = i_rsp_valid;
        rdata = i_rsp_data;
    endtask
endmodule // srs_host_model

`default_nettype wire

// >>> sim/test_status_register_sets.sv
// Self-checking bench for the status register sets, one task per scenario.
// Assumes the host model in srs_host_model and a read answer at the taking edge, sampled at the next falling edge.
`default_nettype none

module test_status_register_sets;
    import srs_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;

    logic clk;
    logic rst;
    logic key;
    logic clr;
    logic pre;
    srs_sensor_t sensor;
    logic [SRS_NUM_SETS-1:1][15:0] raw;
    logic cmd_valid;
    srs_cmd_t cmd;
    logic rsp_valid;
    logic [15:0] rsp_data;
    logic [SRS_NUM_SETS-1:0] summary;
    srs_ext_t ext;
    int bad_count = 0;
    int cmp_count = 0;
    int cycles = 0;

    srs_status_sets i_dut (.i_sys_clk(clk), .i_reset(rst), .i_cmd_valid(cmd_valid), .i_cmd(cmd),
        .i_clear_status(clr), .i_status_preset(pre), .i_sensor(sensor), .i_key_press(key),
        .i_raw_cond(raw), .o_rsp_valid(rsp_valid), .o_rsp_data(rsp_data), .o_set_summary(summary),
        .o_ext(ext));

    srs_host_model i_host (.i_sys_clk(clk), .i_rsp_valid(rsp_valid), .i_rsp_data(rsp_data),
        .o_cmd_valid(cmd_valid), .o_cmd(cmd));

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    task automatic stop_test;
        $display("Comparisons %0d, mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // A hung handshake would otherwise stall the run forever.
    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            bad_count++;
            stop_test();
        end
    end

    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic rd(input logic [3:0] set, input srs_reg_sel_t sel, input logic [15:0] exp);
        logic got;
        logic [15:0] d;
        i_host.issue(set, sel, 1'b0, 16'h0000, got, d);
        check("read answer strobe", {15'h0000, got}, 16'h0001);
        check($sformatf("set %0d %s", set, sel.name()), d, exp);
    endtask

    task automatic wr(input logic [3:0] set, input srs_reg_sel_t sel, input logic [15:0] data);
        logic got;
        logic [15:0] d;
        i_host.issue(set, sel, 1'b1, data, got, d);
        check("write answer strobe", {15'h0000, got}, 16'h0000);
    endtask

    // Kind 0 is a key press, 1 clear-status, 2 status preset; returns where the pulse effects show.
    task automatic strobe(input logic [1:0] kind);
        @(posedge clk);
        key <= (kind == 2'h0);
        clr <= (kind == 2'h1);
        pre <= (kind == 2'h2);
        @(posedge clk);
        key <= 1'b0;
        clr <= 1'b0;
        pre <= 1'b0;
        @(negedge clk);
    endtask

    task automatic sense(input logic [1:0] front, input logic [1:0] rear, input logic [1:0] fail);
        @(posedge clk);
        sensor <= '{front_present: front, rear_present: rear, memory_failed: fail};
        repeat (2) @(posedge clk);
    endtask

    task automatic t_reset;
        rd(4'h0, SRS_REG_ENABLE, 16'h7FFF);
        rd(4'h1, SRS_REG_ENABLE, 16'h0000);
        rd(4'h2, SRS_REG_ENABLE, 16'h0000);
        rd(4'h1, SRS_REG_RISE, 16'h7FFF);
        rd(4'h3, SRS_REG_RISE, 16'h7FFF);
        rd(4'h0, SRS_REG_FALL, 16'h0000);
        rd(4'h0, SRS_REG_EVENT, 16'h0000);
        $display("test reset values done");
    endtask

    task automatic t_masks;
        for (int k = 2; k < 5; k++) begin
            wr(4'h4, srs_reg_sel_t'(k), 16'hFFFF);
            rd(4'h4, srs_reg_sel_t'(k), 16'h7FFF);
            wr(4'h4, srs_reg_sel_t'(k), 16'h8001);
            rd(4'h4, srs_reg_sel_t'(k), 16'h0001);
        end
        rd(4'hB, SRS_REG_ENABLE, 16'h0000);
        $display("test write masks done");
    endtask

    task automatic t_sensor;
        sense(2'h1, 2'h0, 2'h0);
        rd(4'h0, SRS_REG_CONDITION, 16'h0002);
        rd(4'h0, SRS_REG_CONDITION, 16'h0002);
        rd(4'h0, SRS_REG_EVENT, 16'h0002);
        rd(4'h0, SRS_REG_EVENT, 16'h0000);
        sense(2'h1, 2'h3, 2'h0);
        rd(4'h0, SRS_REG_CONDITION, 16'h006E);
        rd(4'h0, SRS_REG_EVENT, 16'h006C);
        sense(2'h0, 2'h0, 2'h2);
        rd(4'h0, SRS_REG_CONDITION, 16'h0010);
        rd(4'h0, SRS_REG_EVENT, 16'h0010);
        sense(2'h0, 2'h0, 2'h0);
        rd(4'h0, SRS_REG_EVENT, 16'h0000);
        $display("test sensor bits done");
    endtask

    task automatic t_removal;
        wr(4'h0, SRS_REG_RISE, 16'h0000);
        wr(4'h0, SRS_REG_FALL, 16'h0006);
        sense(2'h1, 2'h0, 2'h0);
        rd(4'h0, SRS_REG_EVENT, 16'h0000);
        sense(2'h0, 2'h0, 2'h0);
        rd(4'h0, SRS_REG_EVENT, 16'h0002);
        $display("test sensor removal done");
    endtask

    task automatic t_summary;
        wr(4'h0, SRS_REG_ENABLE, 16'h4000);
        rd(4'h0, SRS_REG_ENABLE, 16'h4000);
        strobe(2'h0);
        check("device summary", {15'h0000, summary[0]}, 16'h0001);
        rd(4'h0, SRS_REG_CONDITION, 16'h0000);
        rd(4'h0, SRS_REG_EVENT, 16'h4000);
        @(negedge clk);
        check("device summary cleared", {15'h0000, summary[0]}, 16'h0000);
        @(posedge clk);
        raw[3] <= 16'h0002;
        repeat (2) @(posedge clk);
        @(negedge clk);
        check("child summary", {15'h0000, summary[3]}, 16'h0001);
        rd(4'h1, SRS_REG_CONDITION, 16'h0001);
        $display("test summaries done");
    endtask

    task automatic t_clear;
        wr(4'h0, SRS_REG_ENABLE, 16'h5234);
        strobe(2'h0);
        check("summary before clear", {15'h0000, summary[0]}, 16'h0001);
        strobe(2'h1);
        check("clear pulses", {12'h000, ext}, 16'h000A);
        rd(4'h0, SRS_REG_EVENT, 16'h0000);
        rd(4'h3, SRS_REG_EVENT, 16'h0000);
        rd(4'h0, SRS_REG_ENABLE, 16'h5234);
        $display("test clear status done");
    endtask

    task automatic t_preset;
        strobe(2'h0);
        strobe(2'h2);
        check("preset pulses", {12'h000, ext}, 16'h0004);
        rd(4'h0, SRS_REG_ENABLE, 16'h7FFF);
        rd(4'h0, SRS_REG_RISE, 16'h7FFF);
        rd(4'h0, SRS_REG_FALL, 16'h0000);
        rd(4'h2, SRS_REG_ENABLE, 16'h0000);
        rd(4'h4, SRS_REG_RISE, 16'h7FFF);
        rd(4'h0, SRS_REG_EVENT, 16'h4000);
        $display("test status preset done");
    endtask

    initial begin
        rst = 1'b1;
        key = 1'b0;
        clr = 1'b0;
        pre = 1'b0;
        sensor = '0;
        raw = '0;
        repeat (3) @(posedge clk);
        @(negedge clk);
        check("reset pulses", {12'h000, ext}, 16'h000F);
        @(posedge clk);
        rst <= 1'b0;
        t_reset();
        t_masks();
        t_sensor();
        t_removal();
        t_summary();
        t_clear();
        t_preset();
        stop_test();
    end
endmodule // test_status_register_sets

`default_nettype wire
